// *** rts_reset_seq.sv ***
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
// Functional notes
// RULE_01: power-on starts power-up delay, holding reset
// RULE_02: crystal modes count 1024 oscillator edges after
// RULE_03: leave reset only after start-up count ends
// RULE_04: master clear release after time-outs runs immediately
// RULE_05: brownout flag is bit 0, cleared by brown-out
// RULE_06: software sets brownout flag, checks it later
// RULE_07: brownout flag meaningless while brown-out reset disabled
// RULE_08: power-on flag bit 1, cleared only by power-on
// RULE_09: software sets power-on flag after power-on
// RULE_10: time-out lengths per oscillator mode and cause
// RULE_11: status flag pairs encode the reset cause
// RULE_12: power-on sets both timeout and sleep flags
// RULE_13: resets load 000h, wake-ups continue at next
// RULE_14: interrupt wake with global enable loads vector
// RULE_15: core status reset values per reset type
// RULE_16: resets clear irq control and pc high latch (code keeps irq control bit 0)
// RULE_17: wake-ups keep registers, set wake flag bits
// RULE_18: start-up count only crystal, power-on or wake (code also runs it after the brown-out delay)
// RULE_19: brown-out enable forces the power-up delay
// RULE_20: one hold signal covers master clear and timers
module rts_reset_seq
   import rts_pkg::*;
#(
   parameter int POWERUP_DELAY_TIMER_LEN = POWERUP_DELAY_TIMER_CYCLES,
   parameter int OST_LEN = OST_COUNT
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic master_clear_n,
   input wire logic osc_in,
   // Internal reset and wake sources, one-cycle pulses
   input wire logic por_req,
   input wire logic bor_req,
   input wire logic wdt_timeout,
   input wire logic irq_wake_req,
   input wire logic [7:0] irq_wake_flags,
   // Core state
   input wire logic core_sleeping,
   input wire logic [12:0] pc_current,
   // Core controls
   output logic hold_reset,
   output logic pc_load,
   output logic [12:0] pc_value,
   output logic [7:0] core_status,
   output logic [7:0] irq_control,
   output logic [4:0] pc_high_latch
);

   // Byte address match, shared by read and write decode
   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // Pin synchronisers: index 0 master clear, index 1 oscillator
   logic [1:0] pin_in;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic [1:0] level_reg; // Filtered pin level
   logic [1:0] level_next;
   assign pin_in = {osc_in, master_clear_n};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         // A change counts only once stages two and three agree
         assign level_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi]
                                                                  : level_reg[gi];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_reg[gi] <= 1'b1;
               sync2_reg[gi] <= 1'b1;
               sync3_reg[gi] <= 1'b1;
               level_reg[gi] <= 1'b1;
            end else begin
               sync1_reg[gi] <= pin_in[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
               level_reg[gi] <= level_next[gi];
            end
         end
      end
   endgenerate

   // Pin events
   logic master_clear_n_fall;
   logic osc_rise;
   assign master_clear_n_fall = level_reg[0] & ~level_next[0];
   assign osc_rise = ~level_reg[1] & level_next[1];

   // Software-visible state
   logic [1:0] power_status_reg;
   logic [1:0] power_next;
   logic [7:0] core_status_reg;
   logic [7:0] status_next;
   logic [7:0] irq_control_reg;
   logic [7:0] irq_next;
   logic [4:0] pc_high_reg;
   logic [4:0] pc_high_next;
   logic [3:0] config_reg; // Oscillator mode, timer enable, brown-out enable
   logic [3:0] config_next;
   logic [12:0] pc_value_reg;
   logic [12:0] pc_next;
   logic pc_load_reg;
   logic pc_load_next;
   rts_seq_t state_reg;
   rts_seq_t state_next;
   logic hold_reg;
   logic hold_next;

   // Configuration decode
   rts_osc_t osc_mode;
   logic crystal;
   logic bor_en;
   logic powerup_delay_timer_on;
   assign osc_mode = rts_osc_t'(config_reg[1:0]);
   assign crystal = (osc_mode != OSC_RESISTOR_CAP);
   assign bor_en = config_reg[CFG_BOREN_BIT];
   // Brown-out enable forces the delay even if the enable bit is off (see RULE_19)
   assign powerup_delay_timer_on = ~config_reg[CFG_POWERUP_TIMER_ENABLE_N_N_BIT] | bor_en; // see RULE_01

   // Event priority: power-on, brown-out, master clear, watchdog, interrupt
   logic ev_por;
   logic ev_bor;
   logic ev_master_clear_n;
   logic ev_wdt;
   logic ev_wdt_wake;
   logic ev_irq_wake;
   logic ev_reset;
   logic ev_wake;
   assign ev_por = por_req;
   // Brown-out requests are ignored while disabled (see RULE_07)
   assign ev_bor = ~ev_por & bor_req & bor_en;
   assign ev_master_clear_n = ~ev_por & ~ev_bor & master_clear_n_fall;
   assign ev_wdt = ~ev_por & ~ev_bor & ~ev_master_clear_n & wdt_timeout & ~core_sleeping;
   assign ev_wdt_wake = ~ev_por & ~ev_bor & ~ev_master_clear_n & wdt_timeout & core_sleeping;
   assign ev_irq_wake = ~ev_por & ~ev_bor & ~ev_master_clear_n & ~wdt_timeout & irq_wake_req
                        & core_sleeping;
   assign ev_reset = ev_por | ev_bor | ev_master_clear_n | ev_wdt;
   assign ev_wake = ev_wdt_wake | ev_irq_wake;

   // Time-out counters
   rts_count_if powerup_delay_timer_if ();
   rts_count_if ost_if ();

   // Power-up delay on power-on or brown-out
   assign powerup_delay_timer_if.start = (ev_por & powerup_delay_timer_on) | ev_bor; // see RULE_01
   assign powerup_delay_timer_if.clear = ev_por | ev_bor;
   assign powerup_delay_timer_if.tick = 1'b1;
   // Start-up count follows the delay, or stands alone, in crystal modes
   assign ost_if.start = crystal & ((ev_por & ~powerup_delay_timer_on) | ev_wake
                         | (state_reg == ST_POWERUP_DELAY_TIMER & powerup_delay_timer_if.done)); // see RULE_18
   assign ost_if.clear = ev_por | ev_bor;
   assign ost_if.tick = osc_rise; // see RULE_02

   rts_timeout_counter #(
      .WIDTH(POWERUP_DELAY_TIMER_CNT_W),
      .LIMIT(POWERUP_DELAY_TIMER_CNT_W'(POWERUP_DELAY_TIMER_LEN))
   ) u_powerup_delay_timer (
      .pclk(pclk),
      .presetn(presetn),
      .cnt(powerup_delay_timer_if.counter)
   );

   rts_timeout_counter #(
      .WIDTH(OST_CNT_W),
      .LIMIT(OST_CNT_W'(OST_LEN))
   ) u_osc_startup_counter (
      .pclk(pclk),
      .presetn(presetn),
      .cnt(ost_if.counter)
   );

   // Sequencer next state; the lengths follow mode and cause (see RULE_10)
   always_comb begin
      state_next = state_reg;
      if (ev_por || ev_bor) begin
         if (powerup_delay_timer_if.start) begin
            state_next = ST_POWERUP_DELAY_TIMER;
         end else if (ost_if.start) begin
            state_next = ST_OST;
         end else begin
            state_next = ST_RUN;
         end
      end else if (ev_wake && crystal) begin
         state_next = ST_OST;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               state_next = ST_RUN;
            end
            ST_POWERUP_DELAY_TIMER: begin
               // Resistor-capacitor mode ends with the delay alone
               if (powerup_delay_timer_if.done) begin
                  state_next = crystal ? ST_OST : ST_RUN; // see RULE_02
               end
            end
            ST_OST: begin
               if (ost_if.done) begin
                  state_next = ST_RUN; // see RULE_03
               end
            end
            default: begin
               state_next = ST_RUN;
            end
         endcase
      end
   end

   // One hold covers the pin and every running time-out (see RULE_20)
   // A low pin after the time-outs holds alone, so release is immediate (see RULE_04)
   assign hold_next = (state_next != ST_RUN) | ~level_next[0];

   // APB decode; writes land only in the access cycle that completes
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic wr_en;
   logic setup;
   logic mapped;
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & pready_reg & ~pslverr_reg;
   assign mapped = addr_is(paddr, ADDR_POWER_STATUS) | addr_is(paddr, ADDR_CORE_STATUS)
                   | addr_is(paddr, ADDR_IRQ_CONTROL) | addr_is(paddr, ADDR_PC_HIGH)
                   | addr_is(paddr, ADDR_PC_VALUE) | addr_is(paddr, ADDR_SEQ_STATE)
                   | addr_is(paddr, ADDR_CONFIG);

   // Read data, captured in the setup cycle
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      if (addr_is(paddr, ADDR_POWER_STATUS)) rd_next[1:0] = power_status_reg;
      if (addr_is(paddr, ADDR_CORE_STATUS)) rd_next[7:0] = core_status_reg;
      if (addr_is(paddr, ADDR_IRQ_CONTROL)) rd_next[7:0] = irq_control_reg;
      if (addr_is(paddr, ADDR_PC_HIGH)) rd_next[4:0] = pc_high_reg;
      if (addr_is(paddr, ADDR_PC_VALUE)) rd_next[12:0] = pc_value_reg;
      if (addr_is(paddr, ADDR_SEQ_STATE)) rd_next[3:0] = {level_reg[0], hold_reg, state_reg};
      if (addr_is(paddr, ADDR_CONFIG)) rd_next[3:0] = config_reg;
   end

   // Register next values: software first, hardware events win afterwards
   always_comb begin
      power_next = power_status_reg;
      status_next = core_status_reg;
      irq_next = irq_control_reg;
      pc_high_next = pc_high_reg;
      config_next = config_reg;
      pc_next = pc_value_reg;
      pc_load_next = 1'b0;
      // Software sets the flags it must re-arm (see RULE_06) (see RULE_09)
      if (wr_en && addr_is(paddr, ADDR_POWER_STATUS)) power_next = pwdata[1:0];
      // Timeout and sleep flags are read-only to software
      if (wr_en && addr_is(paddr, ADDR_CORE_STATUS)) begin
         status_next[BANK_MSB:BANK_LSB] = pwdata[BANK_MSB:BANK_LSB];
         status_next[2:0] = pwdata[2:0];
      end
      if (wr_en && addr_is(paddr, ADDR_IRQ_CONTROL)) irq_next = pwdata[7:0];
      if (wr_en && addr_is(paddr, ADDR_PC_HIGH)) pc_high_next = pwdata[4:0];
      if (wr_en && addr_is(paddr, ADDR_CONFIG)) config_next = pwdata[3:0];
      // Full resets restart at zero and clear the control latches, keeping irq control bit 0
      if (ev_reset) begin
         pc_next = PC_RESET; // see RULE_13
         pc_load_next = 1'b1;
         irq_next = {7'h00, irq_control_reg[0]}; // see RULE_16
         pc_high_next = PC_HIGH_RST;
         status_next[BANK_MSB:BANK_LSB] = 3'h0; // see RULE_15
      end
      // Flag pairs by cause (see RULE_11)
      if (ev_por) begin
         power_next[POWERON_BIT] = 1'b0; // see RULE_08
         status_next[TIMEOUT_BIT] = 1'b1; // see RULE_12
         status_next[SLEEP_BIT] = 1'b1;
      end
      if (ev_bor) begin
         power_next[BROWNOUT_BIT] = 1'b0; // see RULE_05
         status_next[TIMEOUT_BIT] = 1'b1;
         status_next[SLEEP_BIT] = 1'b1;
      end
      if (ev_master_clear_n && core_sleeping) begin
         status_next[TIMEOUT_BIT] = 1'b1;
         status_next[SLEEP_BIT] = 1'b0;
      end
      if (ev_wdt) begin
         status_next[TIMEOUT_BIT] = 1'b0;
         status_next[SLEEP_BIT] = 1'b1;
      end
      // Wake-ups resume; only their own flags change (see RULE_17)
      if (ev_wdt_wake) begin
         status_next[TIMEOUT_BIT] = 1'b0;
         status_next[SLEEP_BIT] = 1'b0;
         pc_next = pc_current + PC_STEP; // see RULE_13
         pc_load_next = 1'b1;
      end
      if (ev_irq_wake) begin
         status_next[TIMEOUT_BIT] = 1'b1;
         status_next[SLEEP_BIT] = 1'b0;
         irq_next = irq_control_reg | irq_wake_flags; // see RULE_17
         pc_next = irq_control_reg[GIE_BIT] ? PC_IRQ_VECTOR
                                            : pc_current + PC_STEP; // see RULE_14
         pc_load_next = 1'b1;
      end
   end

   // APB handshake: zero-wait answer in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         if (setup) prdata_reg <= mapped ? rd_next : 32'h0000_0000;
      end
   end

   // Block state; hold starts asserted so the core waits from reset on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_status_reg <= POWER_STATUS_RST;
         core_status_reg <= CORE_STATUS_RST;
         irq_control_reg <= IRQ_CONTROL_RST;
         pc_high_reg <= PC_HIGH_RST;
         config_reg <= CONFIG_RST;
         pc_value_reg <= PC_RESET;
         pc_load_reg <= 1'b0;
         state_reg <= ST_RUN;
         hold_reg <= 1'b1;
      end else begin
         power_status_reg <= power_next;
         core_status_reg <= status_next;
         irq_control_reg <= irq_next;
         pc_high_reg <= pc_high_next;
         config_reg <= config_next;
         pc_value_reg <= pc_next;
         pc_load_reg <= pc_load_next;
         state_reg <= state_next;
         hold_reg <= hold_next;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign hold_reset = hold_reg;
   assign pc_load = pc_load_reg;
   assign pc_value = pc_value_reg;
   assign core_status = core_status_reg;
   assign irq_control = irq_control_reg;
   assign pc_high_latch = pc_high_reg;

   // Checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_powerup_delay_timer_starts: assert property ( // see RULE_01
      ev_por && powerup_delay_timer_on |=> state_reg == ST_POWERUP_DELAY_TIMER && hold_reset ##1 hold_reset)
      else $error("power-up delay did not start on power-on");
   a_ost_follows: assert property ( // see RULE_02
      state_reg == ST_POWERUP_DELAY_TIMER && powerup_delay_timer_if.done && crystal && !ev_por && !ev_bor
      |=> state_reg == ST_OST && ost_if.running)
      else $error("start-up count did not follow the delay");
   a_release_after_ost: assert property ( // see RULE_03
      state_reg == ST_OST && ost_if.done && !ev_por && !ev_bor && level_next[0]
      |=> !hold_reset && $past(hold_reset))
      else $error("reset not released at end of start-up count");
   a_master_clear_n_immediate: assert property ( // see RULE_04
      $rose(level_reg[0]) && state_reg == ST_RUN |-> !hold_reset)
      else $error("master clear release was delayed");
   // Hold leaves reset high for one edge after release, so skip it
   a_hold_sources: assert property ( // see RULE_20
      $past(presetn) |-> hold_reset == ((state_reg != ST_RUN) || !level_reg[0]))
      else $error("hold does not match its sources");
   a_bor_flag: assert property ( // see RULE_05
      ev_bor |=> !power_status_reg[BROWNOUT_BIT] && state_reg == ST_POWERUP_DELAY_TIMER)
      else $error("brown-out did not clear flag or start delay");
   a_por_flag: assert property ( // see RULE_08
      !ev_por && !wr_en |=> power_status_reg[POWERON_BIT] == $past(power_status_reg[POWERON_BIT])
                            || $past(ev_por))
      else $error("power-on flag changed without power-on");
   a_por_status: assert property ( // see RULE_12
      ev_por |=> core_status_reg[TIMEOUT_BIT] && core_status_reg[SLEEP_BIT]
                 && pc_value == PC_RESET && pc_load)
      else $error("power-on status or program counter wrong");
   a_irq_vector: assert property ( // see RULE_14
      ev_irq_wake && irq_control_reg[GIE_BIT] |=> pc_value == PC_IRQ_VECTOR && pc_load)
      else $error("interrupt wake did not load the vector");
   a_rc_no_ost: assert property ( // see RULE_18
      state_reg == ST_OST |-> crystal)
      else $error("start-up count running in resistor-capacitor mode");

endmodule

// *** rts_pkg.sv ***
package rts_pkg;

   // Register byte offsets on the APB port
   localparam logic [7:0] ADDR_POWER_STATUS = 8'h00;
   localparam logic [7:0] ADDR_CORE_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_PC_HIGH = 8'h0c;
   localparam logic [7:0] ADDR_PC_VALUE = 8'h10;
   localparam logic [7:0] ADDR_SEQ_STATE = 8'h14;
   localparam logic [7:0] ADDR_CONFIG = 8'h18;

   // Field positions
   localparam int BROWNOUT_BIT = 0; // power_status_reg: brownout_flag
   localparam int POWERON_BIT = 1; // power_status_reg: power-on status flag
   localparam int TIMEOUT_BIT = 4; // core status: watchdog_expired_n
   localparam int SLEEP_BIT = 3; // core status: sleep_flag_n
   localparam int BANK_MSB = 7; // core status: upper bits cleared by resets
   localparam int BANK_LSB = 5;
   localparam int GIE_BIT = 7; // irq_control_reg: global_irq_enable
   localparam int CFG_POWERUP_TIMER_ENABLE_N_N_BIT = 2; // config: powerup_timer_enable_n
   localparam int CFG_BOREN_BIT = 3; // config: brown-out reset enable

   // Values after reset
   localparam logic [1:0] POWER_STATUS_RST = 2'h0;
   localparam logic [7:0] CORE_STATUS_RST = 8'h18;
   localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
   localparam logic [4:0] PC_HIGH_RST = 5'h00;
   localparam logic [12:0] PC_RESET = 13'h0000;
   localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
   localparam logic [12:0] PC_STEP = 13'h0001;
   localparam logic [3:0] CONFIG_RST = 4'h9;

   // Oscillator modes
   typedef enum logic [1:0] {
      OSC_LOW_POWER_CRYSTAL = 2'b00,
      OSC_STD_CRYSTAL = 2'b01,
      OSC_FAST_CRYSTAL = 2'b10,
      OSC_RESISTOR_CAP = 2'b11
   } rts_osc_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_POWERUP_DELAY_TIMER = 2'b01,
      ST_OST = 2'b10
   } rts_seq_t;

   // Timing
   localparam int CLK_MHZ = 50;
   localparam int POWERUP_DELAY_TIMER_TIME_US = 72000;
   localparam int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_TIME_US * CLK_MHZ;
   localparam int POWERUP_DELAY_TIMER_CNT_W = 22;
   localparam int OST_COUNT = 1024;
   localparam int OST_CNT_W = 11;

endpackage

// *** rts_count_if.sv ***
`timescale 1ns/1ns
// Control and status of one time-out counter
interface rts_count_if;
   logic start; // Restart from zero
   logic clear; // Stop without finishing
   logic tick; // One count step
   logic running; // Counting
   logic done; // One-cycle pulse at the end of the count
   modport counter (input start, input clear, input tick, output running, output done);
   modport owner (output start, output clear, output tick, input running, input done);
endinterface

// *** rts_timeout_counter.sv ***
`timescale 1ns/1ns
module rts_timeout_counter #(
   parameter int WIDTH = 22,
   parameter logic [WIDTH-1:0] LIMIT = '1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control from the sequencer
   rts_count_if.counter cnt
);

   // Last count value before the time-out ends
   localparam logic [WIDTH-1:0] LAST = LIMIT - WIDTH'(1);

   logic [WIDTH-1:0] count_reg; // Steps seen so far
   logic run_reg; // Counter active
   logic done_reg; // End pulse

   // Start beats clear so a restart in the same cycle is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (cnt.start) begin
            count_reg <= '0;
            run_reg <= 1'b1;
         end else if (cnt.clear) begin
            run_reg <= 1'b0;
         end else if (run_reg && cnt.tick) begin
            count_reg <= count_reg + WIDTH'(1);
            if (count_reg == LAST) begin
               run_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end

   assign cnt.running = run_reg;
   assign cnt.done = done_reg;

endmodule

// *** rts_pin_model.sv ***
`timescale 1ns/1ns
// Far side of the sequencer: master-clear pin and crystal oscillator
module rts_pin_model (
   // Clock
   input wire logic pclk,
   // Commands from the bench
   input wire logic pin_low,
   input wire logic osc_run,
   // Pins
   output logic master_clear_n,
   output logic osc_in
);
   logic [1:0] div_reg = 2'h0; // Oscillator phase, one period is four clocks

   // Pin has a pull-up, so it reads high unless held low
   assign master_clear_n = !pin_low;

   // Crystal stands still while stopped, so no count step can leak through
   always_ff @(posedge pclk) begin
      if (!osc_run) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end
   assign osc_in = div_reg[1];
endmodule

// *** test_rts_reset_seq.sv ***
`timescale 1ns/1ns
module test_rts_reset_seq;
   import rts_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pslverr, pready, pin_low, osc_run;
   logic [7:0] paddr, flags;
   logic [31:0] pwdata, prdata;
   logic [3:0] ev; // Event pulses: power-on, brown-out, watchdog, interrupt wake
   logic sleeping, master_clear_n_n, osc, hold_reset, pc_load;
   logic [12:0] pc_cur, pc_value;
   logic [7:0] core_status, irq_control;
   logic [4:0] pc_high_latch;
   logic [32:0] rd_q[$], mk_q[$], pc_q[$]; // Notes of expected results
   int err_total = 0, check_count = 0, cyc = 0;

   rts_reset_seq #(.POWERUP_DELAY_TIMER_LEN(20), .OST_LEN(4)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .master_clear_n(master_clear_n_n),
      .osc_in(osc), .por_req(ev[0]), .bor_req(ev[1]), .wdt_timeout(ev[2]),
      .irq_wake_req(ev[3]), .irq_wake_flags(flags), .core_sleeping(sleeping),
      .pc_current(pc_cur), .hold_reset(hold_reset), .pc_load(pc_load),
      .pc_value(pc_value), .core_status(core_status), .irq_control(irq_control),
      .pc_high_latch(pc_high_latch));
   rts_pin_model u_pins (.pclk(pclk), .pin_low(pin_low), .osc_run(osc_run),
      .master_clear_n(master_clear_n_n), .osc_in(osc));

   // Clock of 20 ns
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic tally_and_finish();
      if (err_total == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Compare under a mask, counting every comparison
   task automatic cmp(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
      check_count++;
      if ((got & m) !== (exp & m)) begin
         err_total++;
         $display("FAIL %0t got %h expected %h", $time, got & m, exp & m);
      end
   endtask

   // Watcher: a read or a program-counter load takes the oldest note
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (rd_q.size() == 0) begin
            cmp(1'b1, 1'b0, 33'h1);
         end else begin
            cmp({pslverr, prdata}, rd_q.pop_front(), mk_q.pop_front());
         end
      end
      if (pc_load === 1'b1) begin
         if (pc_q.size() == 0) begin
            cmp(1'b1, 1'b0, 33'h1);
         end else begin
            cmp({20'h0, pc_value}, pc_q.pop_front(), 33'h1fff);
         end
      end
   end

   // One APB transfer; entered just after a rising edge, only the bench timeout ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read with a noted expectation of {pslverr, data}
   task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
      rd_q.push_back(e);
      mk_q.push_back(m);
      apb(1'b0, a, 32'h0);
   endtask

   // Pulse one event and note the program counter it should load
   task automatic fire(input int i, input logic [12:0] pc);
      pc_q.push_back({20'h0, pc});
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev <= 4'h0;
      @(posedge pclk);
   endtask

   // Bounded wait for the hold level, then compare it
   task automatic wait_hold(input logic v, input int lim);
      int n;
      n = 0;
      while (hold_reset !== v && n < lim) begin
         n++;
         @(posedge pclk);
      end
      cmp(hold_reset, v, 33'h1);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, pin_low, osc_run, sleeping, ev} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      flags = 8'h00;
      pc_cur = 13'h0000;
      void'($urandom(18536));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_CONFIG, 33'h9, 33'h1_0000_000f);
      rd(8'h1c, 33'h1_0000_0000, 33'h1_ffff_ffff); // Unmapped place is refused
      fire(0, 13'h0000);
      rd(ADDR_SEQ_STATE, 33'hd, 33'hf);
      repeat (100) @(posedge pclk);
      rd(ADDR_SEQ_STATE, 33'he, 33'hf);
      cmp(hold_reset, 1'b1, 33'h1);
      osc_run <= 1'b1;
      wait_hold(1'b0, 60);
      rd(ADDR_POWER_STATUS, 33'h0, 33'h2);
      rd(ADDR_CORE_STATUS, 33'h18, 33'h18);
      apb(1'b1, ADDR_POWER_STATUS, 32'h3);
      rd(ADDR_POWER_STATUS, 33'h3, 33'h3);
      fire(1, 13'h0000);
      rd(ADDR_SEQ_STATE, 33'hd, 33'hf);
      rd(ADDR_POWER_STATUS, 33'h2, 33'h3);
      wait_hold(1'b0, 100);
      apb(1'b1, ADDR_CONFIG, 32'h5);
      fire(0, 13'h0000);
      rd(ADDR_SEQ_STATE, 33'he, 33'hf);
      wait_hold(1'b0, 100);
      apb(1'b1, ADDR_CONFIG, 32'h3);
      osc_run <= 1'b0;
      fire(0, 13'h0000);
      wait_hold(1'b0, 60);
      // Pin held low through all time-outs, then released
      apb(1'b1, ADDR_CONFIG, 32'h9);
      osc_run <= 1'b1;
      pc_q.push_back(33'h0);
      pin_low <= 1'b1;
      repeat (10) @(posedge pclk);
      fire(0, 13'h0000);
      repeat (150) @(posedge pclk);
      cmp(hold_reset, 1'b1, 33'h1);
      pin_low <= 1'b0;
      wait_hold(1'b0, 7);
      // Watchdog reset clears control registers
      apb(1'b1, ADDR_IRQ_CONTROL, 32'h80);
      apb(1'b1, ADDR_PC_HIGH, 32'h1f);
      fire(2, 13'h0000);
      rd(ADDR_CORE_STATUS, 33'h08, 33'hf8);
      rd(ADDR_IRQ_CONTROL, 33'h0, 33'hfe);
      rd(ADDR_PC_HIGH, 33'h0, 33'h1f);
      cmp({18'h0, pc_high_latch, core_status[4:3], irq_control}, 33'h100, 33'h7ffe);
      wait_hold(1'b0, 60);
      // Wake-ups from sleep
      sleeping <= 1'b1;
      pc_cur <= 13'($urandom);
      flags <= 8'($urandom) & 8'h7f;
      @(posedge pclk);
      fire(2, pc_cur + 13'h1);
      rd(ADDR_CORE_STATUS, 33'h00, 33'h18);
      wait_hold(1'b0, 60);
      apb(1'b1, ADDR_IRQ_CONTROL, 32'h80);
      fire(3, PC_IRQ_VECTOR);
      rd(ADDR_IRQ_CONTROL, {25'h0, 8'h80 | flags}, 33'hff);
      rd(ADDR_CORE_STATUS, 33'h10, 33'h18);
      wait_hold(1'b0, 60);
      apb(1'b1, ADDR_IRQ_CONTROL, 32'h0);
      fire(3, pc_cur + 13'h1);
      rd(ADDR_IRQ_CONTROL, {25'h0, flags}, 33'hff);
      wait_hold(1'b0, 60);
      repeat (4) @(posedge pclk);
      cmp(rd_q.size() + pc_q.size(), 33'h0, 33'hff);
      tally_and_finish();
   end
endmodule
